//--- hdl/cpss_map.vh
// Address map, field positions, reset values and timing counts for the core state block.
// Assumes it is included by its bare name from the design file.
`ifndef CPSS_MAP_VH
`define CPSS_MAP_VH

// Data space offsets
`define CPSS_OFS_PORT_A_VALUE      8'h00
`define CPSS_OFS_PORT_B_VALUE      8'h01
`define CPSS_OFS_PORT_A_DIRECTION  8'h04
`define CPSS_OFS_PORT_B_DIRECTION  8'h05
`define CPSS_OFS_TIMER_STATUS_CTRL 8'h09
`define CPSS_OFS_CONST_ROM_FIRST   8'h20
`define CPSS_OFS_CONST_ROM_LAST    8'h5f
`define CPSS_OFS_RAM_FIRST         8'h80
`define CPSS_OFS_RAM_LAST          8'h9f
`define CPSS_OFS_POINTER_ONE       8'h80
`define CPSS_OFS_POINTER_TWO       8'h81
`define CPSS_OFS_PRESCALER_COUNT   8'hfd
`define CPSS_OFS_TIMER_COUNT       8'hfe
`define CPSS_OFS_ACCUMULATOR       8'hff
`define CPSS_UNUSED_READ           8'h00

// Program space regions and vectors
`define CPSS_PS_RESERVED_LAST      12'hadf
`define CPSS_PS_RESERVED_READ      8'hff
`define CPSS_VEC_TEST_IRQ          12'hff8
`define CPSS_VEC_TEST_RESTART      12'hffa
`define CPSS_VEC_USER_IRQ          12'hffc
`define CPSS_VEC_USER_RESTART      12'hffe

// Operating modes, decoded from port A lines seven and six
`define CPSS_MODE_SINGLE_CHIP      2'h0
`define CPSS_MODE_SELF_TEST        2'h1
`define CPSS_MODE_ROM_VERIFY       2'h2

// Timer status/control fields and reset values
`define CPSS_TSC_ZERO_BIT          7
`define CPSS_TSC_OUT_MODE_BIT      5
`define CPSS_TSC_DOUT_BIT          4
`define CPSS_TSC_RUN_BIT           3
`define CPSS_TSC_RESET             8'h00
`define CPSS_PRESCALER_RESET       8'hff
`define CPSS_TIMER_COUNT_RESET     8'hff

// Internal sync pulse: clk_sys divided by this count
`define CPSS_SYNC_DIV              6'd48

`endif

//--- hdl/cpss_core_state.v
// Programmer-visible core state: mode straps, program counter, flags, return stack,
// data-space registers, ports and timer. Assumes an instruction sequencer on clk_sys
// drives the strobes below; ROMs answer combinationally to the addresses given.
`timescale 1ns/1ps
`default_nettype none
`include "cpss_map.vh"

module cpss_core_state #(
  parameter RAM_DEPTH = 32,
  parameter STACK_DEPTH = 4
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        srst,
  // Strap and interrupt pins
  input  wire        mode_strap_pin,
  input  wire        irq_pin_n,
  output reg         irq_request_reg,
  output reg  [1:0]  op_mode_reg,
  output reg         core_ready_reg,
  output reg         irq_mask_reg,
  // Program space
  output reg  [11:0] prog_addr_reg,
  input  wire [7:0]  prog_rom_data,
  output reg  [7:0]  prog_fetch_data_reg,
  // Sequencer control
  input  wire        pc_step,
  input  wire        pc_jump,
  input  wire [11:0] pc_jump_addr,
  input  wire        call_push,
  input  wire        ret_pull,
  input  wire        irq_enter,
  input  wire        irq_return,
  output reg  [11:0] program_counter_reg,
  // Flag updates
  input  wire        flag_c_load,
  input  wire        flag_c_value,
  input  wire        flag_z_load,
  input  wire [7:0]  flag_z_result,
  input  wire        rotate_acc,
  output reg         carry_flag_reg,
  output reg         zero_flag_reg,
  output reg         flag_int_sel_reg,
  // Data space
  input  wire [7:0]  ds_addr,
  input  wire        ds_rd,
  input  wire        ds_wr,
  input  wire [7:0]  ds_wdata,
  input  wire [7:0]  const_rom_data,
  output reg  [7:0]  ds_rdata_reg,
  output reg  [7:0]  accumulator_reg,
  output reg  [7:0]  pointer_one_reg,
  output reg  [7:0]  pointer_two_reg,
  // Port A (lines four to seven) and port B
  input  wire [3:0]  port_a_in,
  output reg  [3:0]  port_a_out_reg,
  output reg  [3:0]  port_a_oe_reg,
  input  wire [7:0]  port_b_in,
  output reg  [7:0]  port_b_out_reg,
  output reg  [7:0]  port_b_oe_reg,
  // Timer pin
  input  wire        timer_in,
  output reg         timer_out_reg,
  output reg         timer_oe_reg
);

  localparam PIN_W = 15;
  localparam [1:0] S_MODE = 2'd0;
  localparam [1:0] S_VHI  = 2'd1;
  localparam [1:0] S_VLO  = 2'd2;
  localparam [1:0] S_RUN  = 2'd3;

  // Pin synchronisers: stage 1 only feeds stage 2; filtered level moves when 2 and 3 agree
  wire [PIN_W-1:0] pin_raw;
  reg  [PIN_W-1:0] pin_s1;
  reg  [PIN_W-1:0] pin_s2;
  reg  [PIN_W-1:0] pin_s3;
  reg  [PIN_W-1:0] pin_filt;
  assign pin_raw = {timer_in, irq_pin_n, mode_strap_pin, port_a_in, port_b_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys)
      begin
        pin_s1[gi] <= pin_raw[gi];
        pin_s2[gi] <= pin_s1[gi];
        pin_s3[gi] <= pin_s2[gi];
        if (pin_s2[gi] == pin_s3[gi])
          pin_filt[gi] <= pin_s3[gi];
      end
    end
  endgenerate

  wire [7:0] pb_pin = pin_filt[7:0];
  wire [3:0] pa_pin = pin_filt[11:8];
  wire       strap  = pin_filt[12];
  wire       irq_n  = pin_filt[13];
  wire       tmr_pin = pin_filt[14];

  // Core registers
  reg [1:0]  boot_state_reg;
  reg [11:0] stack_reg [0:STACK_DEPTH-1];
  reg [7:0]  ram_reg [0:RAM_DEPTH-1];
  reg        c_prog_reg;
  reg        z_prog_reg;
  reg        c_int_reg;
  reg        z_int_reg;
  reg [3:0]  port_a_dir_reg;
  reg [7:0]  port_b_dir_reg;
  reg [7:0]  tsc_reg;
  reg [7:0]  prescaler_reg;
  reg [7:0]  timer_count_reg;
  reg [5:0]  sync_cnt_reg;
  reg        tmr_pin_prev_reg;

  wire push_now = call_push | irq_enter;
  wire pull_now = ret_pull | irq_return;
  wire self_test = (op_mode_reg == `CPSS_MODE_SELF_TEST);
  wire [11:0] restart_vec = self_test ? `CPSS_VEC_TEST_RESTART : `CPSS_VEC_USER_RESTART;
  wire [11:0] irq_vec     = self_test ? `CPSS_VEC_TEST_IRQ : `CPSS_VEC_USER_IRQ;

  // Program counter next value (only one sequencer action is expected per cycle)
  reg [11:0] pc_next;
  always @*
  begin
    pc_next = program_counter_reg;
    if (irq_enter)
      pc_next = irq_vec;
    else if (pull_now)
      pc_next = stack_reg[0];
    else if (pc_jump)
      pc_next = pc_jump_addr;
    else if (pc_step)
      pc_next = program_counter_reg + 12'h001;
  end

  // Reset release, mode latch and restart vector fetch
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      boot_state_reg      <= S_MODE;
      op_mode_reg         <= `CPSS_MODE_SINGLE_CHIP;
      core_ready_reg      <= 1'b0;
      program_counter_reg <= 12'h000;
      prog_addr_reg       <= 12'h000;
      irq_mask_reg        <= 1'b1;
    end
    else
    begin
      case (boot_state_reg)
        S_MODE:
        begin
          if (strap)
            op_mode_reg <= {pa_pin[3], pa_pin[2]};
          else
            op_mode_reg <= `CPSS_MODE_SINGLE_CHIP;
          boot_state_reg <= S_VHI;
        end
        S_VHI:
        begin
          prog_addr_reg  <= restart_vec;
          boot_state_reg <= S_VLO;
        end
        S_VLO:
        begin
          program_counter_reg[11:8] <= prog_rom_data[3:0];
          prog_addr_reg             <= restart_vec + 12'h001;
          boot_state_reg            <= S_RUN;
        end
        S_RUN:
        begin
          if (!core_ready_reg)
          begin
            program_counter_reg[7:0] <= prog_rom_data;
            prog_addr_reg            <= {program_counter_reg[11:8], prog_rom_data};
            core_ready_reg           <= 1'b1;
          end
          else
          begin
            program_counter_reg <= pc_next;
            prog_addr_reg       <= pc_next;
            if (irq_enter)
              irq_mask_reg <= 1'b1;
            else if (irq_return)
              irq_mask_reg <= 1'b0;
          end
        end
        default:
          boot_state_reg <= S_MODE;
      endcase
    end
  end

  // Reserved bottom region reads as all ones
  always @(posedge clk_sys)
  begin
    if (srst)
      prog_fetch_data_reg <= `CPSS_PS_RESERVED_READ;
    else if (prog_addr_reg <= `CPSS_PS_RESERVED_LAST)
      prog_fetch_data_reg <= `CPSS_PS_RESERVED_READ;
    else
      prog_fetch_data_reg <= prog_rom_data;
  end

  // Return stack: push shifts down dropping the bottom, pull shifts up keeping the bottom
  generate
    for (gi = 0; gi < STACK_DEPTH; gi = gi + 1)
    begin : g_stack
      always @(posedge clk_sys)
      begin
        if (srst)
          stack_reg[gi] <= 12'h000;
        else if (core_ready_reg && push_now)
          stack_reg[gi] <= (gi == 0) ? program_counter_reg : stack_reg[(gi == 0) ? 0 : gi - 1];
        else if (core_ready_reg && pull_now && gi < STACK_DEPTH - 1)
          stack_reg[gi] <= stack_reg[(gi < STACK_DEPTH - 1) ? gi + 1 : gi];
      end
    end
  endgenerate

  // Flags: only the selected pair moves; the idle pair keeps its value across switches
  wire c_cur = flag_int_sel_reg ? c_int_reg : c_prog_reg;
  wire c_new = rotate_acc ? accumulator_reg[7] : (flag_c_load ? flag_c_value : c_cur);
  wire z_cur = flag_int_sel_reg ? z_int_reg : z_prog_reg;
  wire z_new = flag_z_load ? (flag_z_result == 8'h00) : z_cur;
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      c_prog_reg       <= 1'b0;
      z_prog_reg       <= 1'b0;
      c_int_reg        <= 1'b0;
      z_int_reg        <= 1'b0;
      flag_int_sel_reg <= 1'b0;
      carry_flag_reg   <= 1'b0;
      zero_flag_reg    <= 1'b0;
    end
    else
    begin
      if (flag_int_sel_reg)
      begin
        c_int_reg <= c_new;
        z_int_reg <= z_new;
      end
      else
      begin
        c_prog_reg <= c_new;
        z_prog_reg <= z_new;
      end
      if (core_ready_reg && irq_enter)
      begin
        flag_int_sel_reg <= 1'b1;
        carry_flag_reg   <= c_int_reg;
        zero_flag_reg    <= z_int_reg;
      end
      else if (core_ready_reg && irq_return)
      begin
        flag_int_sel_reg <= 1'b0;
        carry_flag_reg   <= c_prog_reg;
        zero_flag_reg    <= z_prog_reg;
      end
      else
      begin
        carry_flag_reg <= c_new;
        zero_flag_reg  <= z_new;
      end
    end
  end

  wire in_ram = (ds_addr >= `CPSS_OFS_RAM_FIRST) && (ds_addr <= `CPSS_OFS_RAM_LAST);
  wire in_rom = (ds_addr >= `CPSS_OFS_CONST_ROM_FIRST) && (ds_addr <= `CPSS_OFS_CONST_ROM_LAST);
  wire [4:0] ram_idx = ds_addr[4:0];

  // Data RAM, pointers included, as plain flip-flops
  always @(posedge clk_sys)
  begin
    if (ds_wr && in_ram)
      ram_reg[ram_idx] <= ds_wdata;
    pointer_one_reg <= (ds_wr && ds_addr == `CPSS_OFS_POINTER_ONE) ? ds_wdata : ram_reg[0];
    pointer_two_reg <= (ds_wr && ds_addr == `CPSS_OFS_POINTER_TWO) ? ds_wdata : ram_reg[1];
  end

  // Accumulator, ports and directions
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      accumulator_reg <= 8'h00;
      port_a_dir_reg  <= 4'h0;
      port_b_dir_reg  <= 8'h00;
      port_a_oe_reg   <= 4'hf;
      port_b_oe_reg   <= 8'hff;
      port_a_out_reg  <= 4'h0;
      port_b_out_reg  <= 8'h00;
    end
    else
    begin
      if (ds_wr && ds_addr == `CPSS_OFS_ACCUMULATOR)
        accumulator_reg <= ds_wdata;
      else if (rotate_acc)
        accumulator_reg <= {accumulator_reg[6:0], c_cur};
      if (ds_wr && ds_addr == `CPSS_OFS_PORT_A_VALUE)
        port_a_out_reg <= ds_wdata[7:4];
      if (ds_wr && ds_addr == `CPSS_OFS_PORT_B_VALUE)
        port_b_out_reg <= ds_wdata;
      if (ds_wr && ds_addr == `CPSS_OFS_PORT_A_DIRECTION)
      begin
        port_a_dir_reg <= ds_wdata[7:4];
        port_a_oe_reg  <= ~ds_wdata[7:4];
      end
      if (ds_wr && ds_addr == `CPSS_OFS_PORT_B_DIRECTION)
      begin
        port_b_dir_reg <= ds_wdata;
        port_b_oe_reg  <= ~ds_wdata;
      end
    end
  end

  // Timer: prescaler clocked by the filtered pin or by the internal divide-by-48 pulse
  wire out_mode  = tsc_reg[`CPSS_TSC_OUT_MODE_BIT];
  wire sync_tick = (sync_cnt_reg == `CPSS_SYNC_DIV - 6'd1);
  wire pin_rise  = tmr_pin & ~tmr_pin_prev_reg;
  wire pre_tick  = tsc_reg[`CPSS_TSC_RUN_BIT] & (out_mode ? sync_tick : pin_rise);
  wire [7:0] tap_mask = (8'h01 << tsc_reg[2:0]) - 8'h01;
  wire tcr_tick  = pre_tick & ((prescaler_reg[7:0] & tap_mask) == 8'h00);
  wire tsc_wr    = ds_wr && ds_addr == `CPSS_OFS_TIMER_STATUS_CTRL;
  wire pre_wr    = ds_wr && ds_addr == `CPSS_OFS_PRESCALER_COUNT;
  wire tcr_wr    = ds_wr && ds_addr == `CPSS_OFS_TIMER_COUNT;
  // A count write wins over the decrement to zero in the same cycle; a prescaler write only stops it setting the zero bit
  wire hit_zero  = tcr_tick & ~tcr_wr & ~pre_wr & (timer_count_reg == 8'h01);
  wire tsc_rd_clr = ds_rd && ds_addr == `CPSS_OFS_TIMER_STATUS_CTRL && tsc_reg[`CPSS_TSC_ZERO_BIT];
  wire zero_set  = hit_zero | (tcr_wr & ds_wdata == 8'h00) | (tsc_wr & ds_wdata[7]);

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      tsc_reg          <= `CPSS_TSC_RESET;
      prescaler_reg    <= `CPSS_PRESCALER_RESET;
      timer_count_reg  <= `CPSS_TIMER_COUNT_RESET;
      sync_cnt_reg     <= 6'd0;
      tmr_pin_prev_reg <= 1'b0;
      timer_out_reg    <= 1'b1;
      timer_oe_reg     <= 1'b1;
    end
    else
    begin
      tmr_pin_prev_reg <= tmr_pin;
      sync_cnt_reg     <= sync_tick ? 6'd0 : sync_cnt_reg + 6'd1;
      if (tsc_wr)
        tsc_reg[6:0] <= {1'b0, ds_wdata[5:0]};
      // Set beats the read-clear
      if (zero_set)
        tsc_reg[`CPSS_TSC_ZERO_BIT] <= 1'b1;
      else if (tsc_rd_clr)
        tsc_reg[`CPSS_TSC_ZERO_BIT] <= 1'b0;
      if (pre_wr)
        prescaler_reg <= ds_wdata;
      else if (!tsc_reg[`CPSS_TSC_RUN_BIT])
        prescaler_reg <= `CPSS_PRESCALER_RESET;
      else if (pre_tick)
        prescaler_reg <= prescaler_reg - 8'h01;
      if (tcr_wr)
        timer_count_reg <= ds_wdata;
      else if (tcr_tick && timer_count_reg != 8'h00)
        timer_count_reg <= timer_count_reg - 8'h01;
      timer_oe_reg <= ~(tsc_wr ? ds_wdata[`CPSS_TSC_OUT_MODE_BIT] : out_mode);
      if (out_mode && zero_set && !tsc_reg[`CPSS_TSC_ZERO_BIT])
        timer_out_reg <= tsc_reg[`CPSS_TSC_DOUT_BIT];
    end
  end

  // Interrupt pin is asynchronous, so only its filtered copy is used
  always @(posedge clk_sys)
  begin
    if (srst)
      irq_request_reg <= 1'b0;
    else
      irq_request_reg <= ~irq_n;
  end

  // Data-space read mux; ports show the latch for outputs and the pin for inputs
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = `CPSS_UNUSED_READ;
    if (in_ram)
      rd_mux = ram_reg[ram_idx];
    else if (in_rom)
      rd_mux = const_rom_data;
    else
    begin
      case (ds_addr)
        `CPSS_OFS_PORT_A_VALUE:
          rd_mux = {(port_a_dir_reg & port_a_out_reg) | (~port_a_dir_reg & pa_pin), 4'h0};
        `CPSS_OFS_PORT_B_VALUE:
          rd_mux = (port_b_dir_reg & port_b_out_reg) | (~port_b_dir_reg & pb_pin);
        `CPSS_OFS_PORT_A_DIRECTION:
          rd_mux = {port_a_dir_reg, 4'h0};
        `CPSS_OFS_PORT_B_DIRECTION:
          rd_mux = port_b_dir_reg;
        `CPSS_OFS_TIMER_STATUS_CTRL:
          rd_mux = tsc_reg;
        `CPSS_OFS_PRESCALER_COUNT:
          rd_mux = prescaler_reg;
        `CPSS_OFS_TIMER_COUNT:
          rd_mux = timer_count_reg;
        `CPSS_OFS_ACCUMULATOR:
          rd_mux = accumulator_reg;
        default:
          rd_mux = `CPSS_UNUSED_READ;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
      ds_rdata_reg <= 8'h00;
    else if (ds_rd)
      ds_rdata_reg <= rd_mux;
  end

endmodule
`default_nettype wire

//--- testbench/cpss_far_side.sv
// Far-side model: program ROM and constant ROM, both answering combinationally.
// Assumes the block presents registered addresses on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module cpss_far_side (
  // Program space
  input  wire logic [11:0] prog_addr,
  output wire logic [7:0]  prog_rom_data,
  // Constant ROM
  input  wire logic [7:0]  ds_addr,
  output wire logic [7:0]  const_rom_data
);
  // Bytes follow the address, so vectors and stale reads are both predictable
  assign prog_rom_data = prog_addr[7:0] ^ 8'ha5;
  assign const_rom_data = ds_addr ^ 8'h3c;
endmodule

`default_nettype wire

//--- testbench/cpss_core_state_asserts.sv
// Port checks on the core state block.
// Assumes it is bound to every instance of cpss_core_state.
`timescale 1ns/1ps
`default_nettype none

module cpss_core_state_asserts #(
  parameter STACK_DEPTH = 4
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // Sequencer
  input wire logic        core_ready_reg,
  input wire logic [1:0]  op_mode_reg,
  input wire logic        call_push,
  input wire logic        ret_pull,
  input wire logic        irq_enter,
  input wire logic        irq_return,
  input wire logic [11:0] program_counter_reg,
  input wire logic        irq_mask_reg,
  // Flags
  input wire logic        flag_c_load,
  input wire logic        flag_c_value,
  input wire logic        flag_z_load,
  input wire logic [7:0]  flag_z_result,
  input wire logic        rotate_acc,
  input wire logic        carry_flag_reg,
  input wire logic        zero_flag_reg,
  input wire logic        flag_int_sel_reg,
  // Data space
  input wire logic [7:0]  ds_addr,
  input wire logic        ds_rd,
  input wire logic        ds_wr,
  input wire logic [7:0]  ds_wdata,
  input wire logic [7:0]  const_rom_data,
  input wire logic [7:0]  ds_rdata_reg,
  input wire logic [7:0]  accumulator_reg,
  input wire logic [7:0]  pointer_one_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Flag pair switches would hide which pair took a load
  wire quiet_flags = !irq_enter && !irq_return && !rotate_acc;
  wire no_stack    = !call_push && !irq_enter && !ret_pull && !irq_return;

  a_reset_state: assert property (disable iff (1'b0) srst |=> !carry_flag_reg && !zero_flag_reg
    && !flag_int_sel_reg && irq_mask_reg) else $error("flags or mask wrong after reset");
  a_irq_vector: assert property (core_ready_reg && irq_enter |=> flag_int_sel_reg && irq_mask_reg
    && program_counter_reg == ((op_mode_reg == 2'h1) ? 12'hff8 : 12'hffc)) else $error("bad interrupt entry");
  a_irq_return: assert property (core_ready_reg && irq_return && !irq_enter
    |=> !irq_mask_reg && !flag_int_sel_reg) else $error("bad interrupt return");
  a_stack_lifo: assert property (core_ready_reg && call_push && !irq_enter && !ret_pull && !irq_return
    ##1 no_stack ##1 no_stack ##1 ret_pull && !irq_enter && !call_push
    |=> program_counter_reg == $past(program_counter_reg, 4)) else $error("return address lost");
  a_carry_load: assert property (flag_c_load && quiet_flags ##1 quiet_flags && !flag_c_load
    |=> carry_flag_reg == $past(flag_c_value, 2)) else $error("carry not loaded");
  a_zero_load: assert property (flag_z_load && quiet_flags ##1 quiet_flags && !flag_z_load
    |=> zero_flag_reg == ($past(flag_z_result, 2) == 8'h00)) else $error("zero flag wrong");
  a_acc_write: assert property (ds_wr && ds_addr == 8'hff && !rotate_acc
    |=> accumulator_reg == $past(ds_wdata)) else $error("accumulator not written");
  a_pointer_write: assert property (ds_wr && ds_addr == 8'h80
    |=> pointer_one_reg == $past(ds_wdata)) else $error("pointer not written");
  a_unused_read: assert property (ds_rd && (ds_addr inside {[8'h0a:8'h1f], [8'h60:8'h7f], [8'ha0:8'hfc]})
    |=> ds_rdata_reg == 8'h00) else $error("unused location not zero");
  a_const_read: assert property (ds_rd && (ds_addr inside {[8'h20:8'h5f]})
    |=> ds_rdata_reg == $past(const_rom_data)) else $error("constant ROM read wrong");

  c_irq_taken: cover property (core_ready_reg && irq_enter);
  c_call_ret: cover property (call_push ##3 ret_pull);
  c_unused: cover property (ds_rd && ds_addr == 8'h0c);
endmodule

bind cpss_core_state cpss_core_state_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_asserts (
  .clk_sys, .srst, .core_ready_reg, .op_mode_reg, .call_push, .ret_pull, .irq_enter, .irq_return,
  .program_counter_reg, .irq_mask_reg, .flag_c_load, .flag_c_value, .flag_z_load, .flag_z_result,
  .rotate_acc, .carry_flag_reg, .zero_flag_reg, .flag_int_sel_reg, .ds_addr, .ds_rd, .ds_wr,
  .ds_wdata, .const_rom_data, .ds_rdata_reg, .accumulator_reg, .pointer_one_reg
);

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the core state block with a ROM model on its far side.
// Assumes the block, its checker and the far-side model are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} cpss_row_t;
  localparam logic [9:0] S_JMP = 10'h100, S_CALL = 10'h080, S_PULL = 10'h040, S_IRQ = 10'h020;
  localparam logic [9:0] S_RET = 10'h010, S_CL = 10'h008, S_CV = 10'h004, S_ZL = 10'h002, S_ROT = 10'h001;

  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        mode_strap_pin = 1'b0;
  logic        irq_pin_n = 1'b1;
  logic [3:0]  port_a_in = 4'hc;
  logic [7:0]  port_b_in = 8'h3c;
  logic        timer_in = 1'b0;
  logic [9:0]  strb = 10'h000;
  logic [11:0] pc_jump_addr = 12'h000;
  logic [7:0]  flag_z_result = 8'h00;
  logic        ds_rd = 1'b0;
  logic        ds_wr = 1'b0;
  logic [7:0]  ds_addr = 8'h00;
  logic [7:0]  ds_wdata = 8'h00;
  wire         pc_step, pc_jump, call_push, ret_pull, irq_enter, irq_return;
  wire         flag_c_load, flag_c_value, flag_z_load, rotate_acc;
  wire         irq_request_reg, core_ready_reg, irq_mask_reg, carry_flag_reg, zero_flag_reg;
  wire         flag_int_sel_reg, timer_out_reg, timer_oe_reg;
  wire [1:0]   op_mode_reg;
  wire [11:0]  prog_addr_reg, program_counter_reg;
  wire [7:0]   prog_rom_data, prog_fetch_data_reg, const_rom_data, ds_rdata_reg, accumulator_reg;
  wire [7:0]   pointer_one_reg, pointer_two_reg, port_b_out_reg, port_b_oe_reg;
  wire [3:0]   port_a_out_reg, port_a_oe_reg;
  int          miscompares = 0;
  int          compares = 0;
  cpss_row_t   rows [6] = '{'{8'hff, 8'h3c, 8'h3c}, '{8'h80, 8'ha5, 8'ha5}, '{8'h81, 8'h5a, 8'h5a},
                            '{8'h9f, 8'h77, 8'h77}, '{8'h0c, 8'h55, 8'h00}, '{8'h30, 8'h00, 8'h0c}};

  assign {pc_step, pc_jump, call_push, ret_pull, irq_enter, irq_return} = strb[9:4];
  assign {flag_c_load, flag_c_value, flag_z_load, rotate_acc} = strb[3:0];

  cpss_core_state dut (.*);
  cpss_far_side far (.prog_addr(prog_addr_reg), .prog_rom_data, .ds_addr, .const_rom_data);

  initial forever #10 clk_sys = ~clk_sys;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Straps change with reset high so they settle through the synchronisers
  task automatic boot(input logic s, input logic [3:0] pa);
    int n;
    @(posedge clk_sys);
    srst <= 1'b1;
    mode_strap_pin <= s;
    port_a_in <= pa;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    n = 0;
    while (core_ready_reg !== 1'b1 && n < 12)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(core_ready_reg, 1'b1);
  endtask

  // One strobe cycle, then one more so the lagging program fetch data has landed
  task automatic op(input logic [9:0] s, input logic [11:0] a);
    @(posedge clk_sys);
    strb <= s;
    pc_jump_addr <= a;
    flag_z_result <= a[7:0];
    @(posedge clk_sys);
    strb <= 10'h000;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic dsx(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ds_wr <= w;
    ds_rd <= ~w;
    ds_addr <= a;
    ds_wdata <= d;
    @(posedge clk_sys);
    ds_wr <= 1'b0;
    ds_rd <= 1'b0;
    #1;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end

  initial
  begin
    boot(1'b0, 4'hc);
    chk(op_mode_reg, 2'h0);
    chk(program_counter_reg, 12'hb5a);
    chk({flag_int_sel_reg, carry_flag_reg, zero_flag_reg, irq_mask_reg}, 4'h1);
    $display("boot test done");
    for (int i = 0; i < 6; i++)
    begin
      dsx(1'b1, rows[i].a, rows[i].w);
      dsx(1'b0, rows[i].a, 8'h00);
      chk(ds_rdata_reg, rows[i].e);
    end
    chk(pointer_two_reg, 8'h5a);
    $display("data space test done");
    @(posedge clk_sys);
    irq_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(irq_request_reg, 1'b1);
    irq_pin_n <= 1'b1;
    op(S_CL | S_CV | S_ZL, 12'h000);
    chk({carry_flag_reg, zero_flag_reg}, 2'h3);
    op(S_IRQ, 12'h000);
    chk({flag_int_sel_reg, irq_mask_reg, carry_flag_reg, zero_flag_reg}, 4'hc);
    chk(program_counter_reg, 12'hffc);
    op(S_CL | S_CV | S_ZL, 12'h005);
    chk({carry_flag_reg, zero_flag_reg}, 2'h2);
    op(S_RET, 12'h000);
    chk({flag_int_sel_reg, irq_mask_reg, carry_flag_reg, zero_flag_reg}, 4'h3);
    chk(program_counter_reg, 12'hb5a);
    op(S_IRQ, 12'h000);
    chk({carry_flag_reg, zero_flag_reg}, 2'h2);
    op(S_RET, 12'h000);
    dsx(1'b1, 8'hff, 8'h41);
    op(S_ROT, 12'h000);
    chk({carry_flag_reg, accumulator_reg}, 12'h083);
    $display("flag and interrupt test done");
    op(S_JMP, 12'hc10);
    chk(prog_fetch_data_reg, 8'hb5);
    op(S_JMP, 12'h100);
    chk(prog_fetch_data_reg, 8'hff);
    for (int i = 1; i < 6; i++)
      op(S_CALL | S_JMP, 12'h100 + i[11:0]);
    chk(program_counter_reg, 12'h105);
    chk(prog_addr_reg, 12'h105);
    for (int i = 0; i < 6; i++)
    begin
      op(S_PULL, 12'h000);
      chk(program_counter_reg, (i < 4) ? 12'h104 - i[11:0] : 12'h101);
    end
    $display("stack test done");
    dsx(1'b1, 8'h05, 8'h0f);
    dsx(1'b1, 8'h01, 8'ha6);
    dsx(1'b1, 8'h04, 8'hc0);
    chk({port_b_oe_reg, port_a_oe_reg}, 12'hf03);
    chk(port_b_out_reg, 8'ha6);
    dsx(1'b0, 8'h01, 8'h00);
    chk(ds_rdata_reg, 8'h36);
    dsx(1'b1, 8'h00, 8'h90);
    chk(port_a_out_reg, 4'h9);
    $display("port test done");
    // Input mode, divide by one: two pin rises take the count from two to zero
    dsx(1'b1, 8'h09, 8'h08);
    dsx(1'b1, 8'hfe, 8'h02);
    repeat (2)
    begin
      @(posedge clk_sys);
      timer_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      timer_in <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
    dsx(1'b0, 8'h09, 8'h00);
    chk(ds_rdata_reg, 8'h88);
    chk(timer_oe_reg, 1'b1);
    // Output mode: forcing the count to zero latches the data bit onto the pin
    dsx(1'b1, 8'h09, 8'h28);
    dsx(1'b1, 8'hfe, 8'h00);
    chk({timer_oe_reg, timer_out_reg}, 2'h0);
    $display("timer test done");
    boot(1'b1, 4'h4);
    chk(op_mode_reg, 2'h1);
    op(S_IRQ, 12'h000);
    chk(program_counter_reg, 12'hff8);
    boot(1'b1, 4'h8);
    chk(op_mode_reg, 2'h2);
    $display("mode test done");
    final_report();
  end
endmodule

`default_nettype wire
